/* File: core/bit_sync.sv */
// Purpose: two-flop level synchroniser, one per bit
// Assumes: inputs are levels that stay put for several clocks
// Notes: only the second stage may be read by other logic

`timescale 1ns/1ps

module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // ==========================================================
   // stages
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end

endmodule

/* File: core/smb_link.sv */
// Purpose: bit and byte engine clocked by the bus clock itself
// Assumes: link_clr is held while the bus clock is high around start/stop
// Notes: samples data on rising edges, drives the data line on falling edges

`timescale 1ns/1ps

module smb_link (
   input wire logic scl,
   input wire logic link_clr,
   input wire logic sda_in,
   input wire logic [smb_pkg::BYTE_W-1:0] rd_byte,
   output logic sda_oe,
   output logic evt_tog,
   output smb_pkg::link_evt_t evt
);
   import smb_pkg::*;

   link_state_t state, next_state;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic is_read, next_is_read;
   logic [1:0] byte_idx, next_byte_idx;
   logic next_evt_tog;
   link_evt_t next_evt;
   logic next_sda_oe;
   logic [7:0] byte_in;

   // ==========================================================
   // rising-edge sampling
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_is_read = is_read;
      next_byte_idx = byte_idx;
      next_evt_tog = evt_tog;
      next_evt = evt;
      byte_in = {shreg[6:0], sda_in};
      unique case (state)
         LK_ADDR: begin
            next_shreg = byte_in;
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == LAST_BIT) begin
               if (byte_in[7:1] == DEV_ADDR) begin
                  next_state = LK_ACK_ADDR;
                  next_is_read = byte_in[0];
               end else begin
                  next_state = LK_IGNORE;
               end
            end
         end
         LK_ACK_ADDR: begin
            next_bit_cnt = 3'h0;
            if (is_read) begin
               next_state = LK_TX;
               next_shreg = rd_byte;
            end else begin
               next_state = LK_RX;
            end
         end
         LK_RX: begin
            next_shreg = byte_in;
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == LAST_BIT) begin
               // a third write byte gets no acknowledge
               if (byte_idx < MAX_WR_BYTES) begin
                  next_state = LK_ACK_RX;
                  next_evt.is_data = (byte_idx != 2'h0);
                  next_evt.data = byte_in;
                  next_evt_tog = ~evt_tog;
               end else begin
                  next_state = LK_IGNORE;
               end
            end
         end
         LK_ACK_RX: begin
            next_state = LK_RX;
            next_bit_cnt = 3'h0;
            next_byte_idx = 2'(byte_idx + 2'h1);
         end
         LK_TX: begin
            next_shreg = {shreg[6:0], 1'b0};
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == LAST_BIT) begin
               next_state = LK_ACK_TX;
            end
         end
         LK_ACK_TX: begin
            next_state = LK_IGNORE;
         end
         LK_IGNORE: begin
            next_state = LK_IGNORE;
         end
         default: begin
            next_state = LK_IGNORE;
         end
      endcase
   end

   always_ff @(posedge scl or posedge link_clr) begin
      if (link_clr) begin
         state <= LK_ADDR;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         is_read <= 1'b0;
         byte_idx <= 2'h0;
         evt_tog <= 1'b0;
         evt <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         is_read <= next_is_read;
         byte_idx <= next_byte_idx;
         evt_tog <= next_evt_tog;
         evt <= next_evt;
      end
   end

   // ==========================================================
   // falling-edge drive, so the line only moves while the clock is low
   always_comb begin
      next_sda_oe = (state == LK_ACK_ADDR) || (state == LK_ACK_RX) ||
                    ((state == LK_TX) && !shreg[7]);
   end

   always_ff @(negedge scl or posedge link_clr) begin
      if (link_clr) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= next_sda_oe;
      end
   end

endmodule

/* File: core/smb_pkg.sv */
// Purpose: shared constants and types of the management bus slave port
// Assumes: 20 MHz system clock, byte-wide internal registers
// Notes: no process here, definitions only

package smb_pkg;

   // ==========================================================
   // bus address and byte framing
   localparam logic [6:0] DEV_ADDR = 7'h2e;
   localparam logic [7:0] DEV_ADDR_WR = 8'h5c;
   localparam int unsigned BYTE_W = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] MAX_WR_BYTES = 2'h2;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] RD_RESET = 8'h00;

   // ==========================================================
   // timing
   localparam int unsigned SYS_CLK_KHZ = 20000;
   localparam int unsigned TIMEOUT_MS = 35;
   localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * SYS_CLK_KHZ;
   localparam int unsigned TIMEOUT_CNT_W = $clog2(TIMEOUT_CYCLES + 1);

   // ==========================================================
   // link engine states and the byte event it hands over
   typedef enum logic [2:0] {
      LK_ADDR,
      LK_ACK_ADDR,
      LK_RX,
      LK_ACK_RX,
      LK_TX,
      LK_ACK_TX,
      LK_IGNORE
   } link_state_t;

   typedef struct packed {
      logic is_data;
      logic [7:0] data;
   } link_evt_t;

endpackage

/* File: core/smb_slave.sv */
// Purpose: management bus slave port with address pointer and byte access
// Assumes: scl and sda arrive from pins; reg_rdata follows reg_addr
// Notes: link engine runs on scl, frame control on sys_clk

`timescale 1ns/1ps

module smb_slave #(
   parameter int unsigned TIMEOUT_CYC = smb_pkg::TIMEOUT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic bus_timeout_disable,
   input wire logic [smb_pkg::BYTE_W-1:0] reg_rdata,
   output logic [smb_pkg::BYTE_W-1:0] reg_addr,
   output logic [smb_pkg::BYTE_W-1:0] reg_wdata,
   output logic reg_wr
);
   import smb_pkg::*;

   localparam logic [TIMEOUT_CNT_W-1:0] TO_LAST = TIMEOUT_CNT_W'(TIMEOUT_CYC - 1);

   // ==========================================================
   // pin and event synchronisers
   logic [1:0] pins_s;
   logic scl_s, sda_s;
   logic tog_s;
   logic evt_tog;
   link_evt_t evt;

   bit_sync #(
      .W(2)
   ) u_pin_sync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d({scl, sda_in}),
      .q(pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   bit_sync #(
      .W(1)
   ) u_evt_sync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d(evt_tog),
      .q(tog_s)
   );

   // ==========================================================
   // link engine
   logic link_clr;
   logic [7:0] rd_shadow;

   smb_link u_link (
      .scl(scl),
      .link_clr(link_clr),
      .sda_in(sda_in),
      .rd_byte(rd_shadow),
      .sda_oe(sda_oe),
      .evt_tog(evt_tog),
      .evt(evt)
   );

   // open-drain: only ever pulls low
   assign sda_out = 1'b0;

   // ==========================================================
   // start, stop and activity detection
   logic scl_d, sda_d, tog_d;
   logic next_scl_d, next_sda_d, next_tog_d;
   logic start_det, stop_det, activity, evt_pulse;

   always_comb begin
      next_scl_d = scl_s;
      next_sda_d = sda_s;
      next_tog_d = tog_s;
      start_det = scl_s && scl_d && sda_d && !sda_s;
      stop_det = scl_s && scl_d && !sda_d && sda_s;
      activity = (scl_s != scl_d) || (sda_s != sda_d);
      // clearing the link also zeroes its toggle; that echo is no byte event
      evt_pulse = (tog_s != tog_d) && !link_clr;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         tog_d <= 1'b0;
      end else begin
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
         tog_d <= next_tog_d;
      end
   end

   // ==========================================================
   // frame control: the link engine is held clear between frames
   // and across each start while the clock is still high
   logic armed, next_armed;
   logic next_link_clr;
   logic timeout;
   logic [TIMEOUT_CNT_W-1:0] idle_cnt, next_idle_cnt;

   always_comb begin
      next_link_clr = link_clr;
      next_armed = armed;
      if (start_det) begin
         next_link_clr = 1'b1;
         next_armed = 1'b1;
      end else if (stop_det || timeout) begin
         next_link_clr = 1'b1;
         next_armed = 1'b0;
      end else if (armed && !scl_s) begin
         // release only after the clock fell, far from its next rising edge
         next_link_clr = 1'b0;
         next_armed = 1'b0;
      end
   end

   // counter only runs inside a frame; a stuck-low clock also trips it
   always_comb begin
      timeout = !link_clr && !bus_timeout_disable && (idle_cnt == TO_LAST);
      if (link_clr || bus_timeout_disable || activity) begin
         next_idle_cnt = '0;
      end else if (idle_cnt == TO_LAST) begin
         next_idle_cnt = idle_cnt;
      end else begin
         next_idle_cnt = TIMEOUT_CNT_W'(idle_cnt + 1'b1);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_clr <= 1'b1;
         armed <= 1'b0;
         idle_cnt <= '0;
      end else begin
         link_clr <= next_link_clr;
         armed <= next_armed;
         idle_cnt <= next_idle_cnt;
      end
   end

   // ==========================================================
   // pointer, register write and read shadow
   logic [7:0] next_reg_addr, next_reg_wdata, next_rd_shadow;
   logic next_reg_wr;

   always_comb begin
      next_reg_addr = reg_addr;
      next_reg_wdata = reg_wdata;
      next_reg_wr = 1'b0;
      // the shadow freezes during a frame so the link sees a stable byte
      next_rd_shadow = link_clr ? reg_rdata : rd_shadow;
      if (evt_pulse) begin
         if (!evt.is_data) begin
            next_reg_addr = evt.data;
         end else begin
            next_reg_wdata = evt.data;
            next_reg_wr = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_addr <= PTR_RESET;
         reg_wdata <= 8'h00;
         reg_wr <= 1'b0;
         rd_shadow <= RD_RESET;
      end else begin
         reg_addr <= next_reg_addr;
         reg_wdata <= next_reg_wdata;
         reg_wr <= next_reg_wr;
         rd_shadow <= next_rd_shadow;
      end
   end

   // ==========================================================
   // checks
   sequence s_ptr_evt;
      evt_pulse && !evt.is_data;
   endsequence

   sequence s_data_evt;
      evt_pulse && evt.is_data;
   endsequence

   property p_ptr_load;
      @(posedge sys_clk) disable iff (!rst_n)
      s_ptr_evt |=> (reg_addr == $past(evt.data)) && !reg_wr;
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("pointer byte not loaded");

   property p_data_write;
      @(posedge sys_clk) disable iff (!rst_n)
      s_data_evt |=> reg_wr && (reg_wdata == $past(evt.data)) &&
                     (reg_addr == $past(reg_addr));
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("data byte not written at pointer");

   property p_wr_single;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_wr |=> !reg_wr;
   endproperty
   a_wr_single: assert property (p_wr_single)
      else $error("write strobe longer than one cycle");

   property p_ptr_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !evt_pulse |=> $stable(reg_addr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold)
      else $error("pointer moved without a pointer byte");

   property p_shadow;
      @(posedge sys_clk) disable iff (!rst_n)
      link_clr |=> rd_shadow == $past(reg_rdata);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("read shadow not tracking between frames");

   property p_shadow_frozen;
      @(posedge sys_clk) disable iff (!rst_n)
      !link_clr ##1 !link_clr |-> $stable(rd_shadow);
   endproperty
   a_shadow_frozen: assert property (p_shadow_frozen)
      else $error("read shadow changed inside a frame");

   property p_start_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      start_det |=> link_clr && armed;
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("start did not restart the link engine");

   property p_stop_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      stop_det && !start_det |=> link_clr && !armed;
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("stop did not end the frame");

   property p_release_after_start;
      @(posedge sys_clk) disable iff (!rst_n)
      armed && !scl_s && !start_det && !stop_det |=> !link_clr;
   endproperty
   a_release_after_start: assert property (p_release_after_start)
      else $error("link engine not released after start");

   property p_timeout_fire;
      @(posedge sys_clk) disable iff (!rst_n)
      (idle_cnt == TO_LAST) && !link_clr && !bus_timeout_disable |=> link_clr;
   endproperty
   a_timeout_fire: assert property (p_timeout_fire)
      else $error("bus timeout did not release the bus");

   property p_timeout_off;
      @(posedge sys_clk) disable iff (!rst_n)
      bus_timeout_disable |=> idle_cnt == '0;
   endproperty
   a_timeout_off: assert property (p_timeout_off)
      else $error("timeout counter ran while disabled");

   property p_idle_released;
      @(posedge sys_clk) disable iff (!rst_n)
      link_clr [*2] |-> !sda_oe;
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("data line driven outside a frame");

endmodule

/* File: tb/smb_host_model.sv */
// Purpose: behavioural bus master driving the clock and data lines of the slave port
// Assumes: data line has a pull-up, so a released line reads high
// Notes: bus clock phases are counted on a free 32 ns timebase; clock stands still outside frames

`timescale 1ns/1ps

module smb_host_model (
   output logic scl,
   output logic sda_rel,
   input wire logic sda_wire
);
   logic tick;

   // ==========================================================
   // timebase, unrelated in phase to the system clock
   initial begin
      scl = 1'h1;
      sda_rel = 1'h1;
      tick = 1'h0;
      #7;
      forever #16 tick = ~tick;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge tick);
   endtask

   // ==========================================================
   // framing; start also serves as repeated start from clock low
   task automatic start();
      sda_rel = 1'h1;
      wt(4);
      scl = 1'h1;
      wt(8);
      sda_rel = 1'h0;
      wt(8);
      scl = 1'h0;
      wt(4);
   endtask

   task automatic stop();
      sda_rel = 1'h0;
      wt(4);
      scl = 1'h1;
      wt(8);
      sda_rel = 1'h1;
      wt(8);
   endtask

   // let go of the data line while the clock is low
   task automatic free_sda();
      sda_rel = 1'h1;
   endtask

   // data changes only in the low phase, sampled mid high phase
   task automatic bitx(input logic b, output logic s);
      sda_rel = b;
      wt(4);
      scl = 1'h1;
      wt(4);
      s = sda_wire;
      wt(4);
      scl = 1'h0;
      wt(4);
   endtask

   task automatic bits8(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], s);
      end
   endtask

   // write direction stays fixed for the whole frame
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      bits8(d);
      bitx(1'h1, s);
      ack = ~s;
   endtask

   // single read byte, ended by not-acknowledge
   task automatic rbyte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'h1, d[i]);
      end
      bitx(1'h1, s);
   endtask
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the management bus slave port
// Assumes: short bus timeout of 200 system cycles
// Notes: register file behind the port is modelled here as plain memory

`timescale 1ns/1ps

module tb_top;
   import smb_pkg::*;

   logic sys_clk;
   logic rst_n;
   logic scl;
   logic sda_rel;
   logic sda_out;
   logic sda_oe;
   logic sda_wire;
   logic bus_timeout_disable;
   logic [7:0] reg_rdata;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic [7:0] mem [256];
   logic [7:0] expv [256];
   logic [15:0] wq [$];
   logic [31:0] seed;
   int bad_count;
   int total_checks;

   // ==========================================================
   // wiring: open drain with pull-up
   assign sda_wire = sda_rel & ~(sda_oe & ~sda_out);
   assign reg_rdata = mem[reg_addr];

   smb_slave #(.TIMEOUT_CYC(200)) u_dut (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .scl(scl),
      .sda_in(sda_wire),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .bus_timeout_disable(bus_timeout_disable),
      .reg_rdata(reg_rdata),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr)
   );

   smb_host_model u_host (
      .scl(scl),
      .sda_rel(sda_rel),
      .sda_wire(sda_wire)
   );

   always #25 sys_clk = ~sys_clk;

   // ==========================================================
   // compare tasks and verdict
   task automatic chk_ack(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t ack got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      if (wq.size() != 0) begin
         bad_count++;
         $display("MISMATCH %0t register writes missing", $time);
      end
      if (bad_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // ==========================================================
   // user register file and write monitor
   always @(posedge sys_clk) begin
      if (reg_wr === 1'h1) begin
         mem[reg_addr] <= reg_wdata;
         if (wq.size() == 0) begin
            bad_count++;
            $display("MISMATCH %0t unexpected register write", $time);
         end else begin
            chk_byte(reg_addr, wq[0][15:8]);
            chk_byte(reg_wdata, wq[0][7:0]);
            void'(wq.pop_front());
         end
      end
   end

   // ==========================================================
   // frame tasks
   task automatic wframe(input logic [7:0] cmd, input logic [7:0] dat, input int n,
                         input logic end_stop);
      logic a;
      u_host.start();
      u_host.wbyte(DEV_ADDR_WR, a);
      chk_ack(a, 1'h1);
      u_host.wbyte(cmd, a);
      chk_ack(a, 1'h1);
      if (n > 1) begin
         wq.push_back({cmd, dat});
         expv[cmd] = dat;
         u_host.wbyte(dat, a);
         chk_ack(a, 1'h1);
      end
      if (n > 2) begin
         u_host.wbyte(~dat, a);
         chk_ack(a, 1'h0);
      end
      if (end_stop) begin
         u_host.stop();
      end
   endtask

   task automatic rframe(input logic [7:0] exp);
      logic a;
      logic [7:0] d;
      u_host.start();
      u_host.wbyte({DEV_ADDR, 1'h1}, a);
      chk_ack(a, 1'h1);
      u_host.rbyte(d);
      chk_byte(d, exp);
      u_host.stop();
   endtask

   // ack released by the bus timeout on a stalled clock, held only with the timeout disabled; checked after a long wait
   task automatic stall(input logic dis, input logic exp);
      logic s;
      @(negedge sys_clk);
      bus_timeout_disable = dis;
      u_host.start();
      u_host.bits8(DEV_ADDR_WR);
      // last address bit is low; free the line so only the slave can hold it
      u_host.free_sda();
      u_host.wt(400);
      chk_ack(sda_wire, exp);
      u_host.bitx(1'h1, s);
      u_host.stop();
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] c0;
      logic [7:0] c;
      logic [7:0] d;
      logic a;
      sys_clk = 1'h0;
      rst_n = 1'h0;
      bus_timeout_disable = 1'h0;
      seed = 32'h640f_a54d;
      bad_count = 0;
      total_checks = 0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
         expv[i] = 8'h00;
      end
      repeat (20) @(negedge sys_clk);
      rst_n = 1'h1;
      repeat (4) @(negedge sys_clk);
      c0 = 8'(xs());
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? c0 : 8'(xs());
         d = 8'(xs());
         wframe(c, d, 2, 1'h1);
         rframe(d);
      end
      // pointer set by send byte, read after repeated start
      wframe(c0, 8'h00, 1, 1'h0);
      rframe(expv[c0]);
      for (int k = 0; k < 3; k++) begin
         u_host.start();
         u_host.wbyte({(k == 0) ? 7'h2f : (k == 1) ? 7'h0c : 7'h6e, 1'h0}, a);
         chk_ack(a, 1'h0);
         u_host.wbyte(8'h00, a);
         chk_ack(a, 1'h0);
         u_host.stop();
      end
      rframe(expv[c0]);
      c = 8'(xs());
      d = 8'(xs());
      wframe(c, d, 3, 1'h1);
      rframe(d);
      stall(1'h0, 1'h1);
      stall(1'h1, 1'h0);
      rframe(d);
      final_report();
   end

   // ==========================================================
   // watchdog, well beyond the expected run of some 300 us
   initial begin
      #2_000_000;
      bad_count++;
      final_report();
   end
endmodule
